// [m13cfg_pkg.sv]
// Notes on behaviour
// - Writable configuration bits read back as written
// - Reset clears writable bits unless noted
// - Writes to read-only bits change nothing
// - Software reset bit holds device until cleared
// - Hardware reset clears the software reset bit
// - Receive clock edge sets flag; read clears
// - Transmit reference edge sets flag; read clears
// - External tributary clock edge sets flag; read clears
// - Offset one reads a fixed version code
// - Write to offset one updates all counters
// - Bypassed group takes line 4n, ignores others
// - Bypassed group drives line 4n, others low
// - Source select picks generated or external clock
// - Receive select swaps interrupt/message for clock/data
// - Transmit select turns data pin into input
// - Transmit external select resets to one
// - Message polarity: open-drain low or strong high

package m13cfg_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_MASTER = 8'h00;
    localparam logic [7:0] ADDR_REVISION = 8'h01;
    localparam logic [7:0] ADDR_BYPASS = 8'h02;
    localparam logic [7:0] ADDR_LINK_CFG = 8'h03;

    // ==========================================================
    // Field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_RX_ACT = 7;
    localparam int BIT_TX_ACT = 6;
    localparam int BIT_EXT_ACT = 5;
    localparam int BIT_SRC_SEL = 7;
    localparam int BIT_RX_EXT = 7;
    localparam int BIT_TX_EXT = 6;
    localparam int BIT_EOM_POL = 3;

    // ==========================================================
    // Reset values
    localparam logic RST_SOFT_RESET = 1'b0;
    localparam logic [6:0] RST_BYPASS = 7'h00;
    localparam logic RST_SRC_SEL = 1'b0;
    localparam logic RST_RX_EXT = 1'b0;
    localparam logic RST_TX_EXT = 1'b1;
    localparam logic [3:0] RST_POL = 4'h0;

    // ==========================================================
    // Structure
    localparam int NUM_GROUPS = 7;
    localparam int LINES_PER_GROUP = 4;
    localparam int NUM_LINES = NUM_GROUPS * LINES_PER_GROUP;
    localparam int NUM_ACT = 3;
    localparam int BUS_SYNC_W = 20;
    // Idle bus pin levels: chip select and strobes high, so reset makes no strobe
    localparam logic [BUS_SYNC_W-1:0] RST_BUS_SYNC = 20'hb0000;

endpackage

// [m13cfg_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for pins from outside the clock domain
module m13cfg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0 // Idle level of the pins
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import m13cfg_pkg::*;

    // ==========================================================
    // Elaboration check
    if (WIDTH < 1) begin : g_bad_width
        $error("m13cfg_sync needs a width of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1; // Meta stage, read only by stage2
        logic [WIDTH-1:0] stage2; // Safe stage
    } m13cfg_sync_s;

    m13cfg_sync_s st;
    m13cfg_sync_s next_st;

    // Shift the pin through both stages
    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Idle level, so no false strobe or edge follows reset
            st.stage1 <= RESET_VALUE;
            st.stage2 <= RESET_VALUE;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule // m13cfg_sync

`default_nettype wire

// [m13cfg_link_pins.sv]
`timescale 1ns/1ps
`default_nettype none

// Shared data-link pin steering and drive polarity
module m13cfg_link_pins (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_external_link_sel,
    input wire logic tx_external_link_sel,
    input wire logic [3:0] polarity,
    input wire logic rx_link_interrupt,
    input wire logic rx_link_end_of_message,
    input wire logic rx_link_serial_data,
    input wire logic rx_link_serial_clock,
    input wire logic tx_link_interrupt,
    input wire logic tx_link_underrun,
    input wire logic tx_link_serial_clock,
    input wire logic tx_sig_pin_in,
    output logic rx_clk_pin_out,
    output logic rx_clk_pin_oe,
    output logic rx_sig_pin_out,
    output logic rx_sig_pin_oe,
    output logic tx_clk_pin_out,
    output logic tx_clk_pin_oe,
    output logic tx_sig_pin_out,
    output logic tx_sig_pin_oe,
    output logic tx_link_serial_data
);
    import m13cfg_pkg::*;

    typedef struct packed {
        logic [7:0] pins; // Out and enable pairs, four pins
        logic sig_meta; // First synchroniser stage
        logic sig_sync; // Second synchroniser stage
        logic tx_data; // Data bit for the transmitter
    } m13cfg_link_s;

    m13cfg_link_s st;
    m13cfg_link_s next_st;

    // Open-drain low when polarity is zero, strong high when one
    function automatic logic [1:0] drive(input logic active, input logic pol);
        drive = pol ? {active, 1'b1} : {1'b0, active};
    endfunction

    // Pick each pin's source and drive
    always_comb begin
        next_st = st;
        next_st.sig_meta = tx_sig_pin_in;
        next_st.sig_sync = st.sig_meta;
        if (rx_external_link_sel) begin
            next_st.pins[7:6] = {rx_link_serial_clock, 1'b1};
            next_st.pins[5:4] = {rx_link_serial_data, 1'b1};
        end else begin
            next_st.pins[7:6] = drive(rx_link_interrupt, polarity[1]);
            next_st.pins[5:4] = drive(rx_link_end_of_message, polarity[BIT_EOM_POL]);
        end
        if (tx_external_link_sel) begin
            next_st.pins[3:2] = {tx_link_serial_clock, 1'b1};
            next_st.pins[1:0] = 2'h0;
            next_st.tx_data = st.sig_sync;
        end else begin
            next_st.pins[3:2] = drive(tx_link_interrupt, polarity[0]);
            next_st.pins[1:0] = drive(tx_link_underrun, polarity[2]);
            next_st.tx_data = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign {rx_clk_pin_out, rx_clk_pin_oe} = st.pins[7:6];
    assign {rx_sig_pin_out, rx_sig_pin_oe} = st.pins[5:4];
    assign {tx_clk_pin_out, tx_clk_pin_oe} = st.pins[3:2];
    assign {tx_sig_pin_out, tx_sig_pin_oe} = st.pins[1:0];
    assign tx_link_serial_data = st.tx_data;

endmodule // m13cfg_link_pins

`default_nettype wire

// [m13cfg_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// Master configuration register bank
module m13cfg_regs #(
    parameter logic [7:0] VERSION_CODE = 8'h5a // Arbitrary value
) (
    input wire logic clk,
    input wire logic nrst,
    // Processor bus pins
    input wire logic chip_select_n,
    input wire logic test_register_select,
    input wire logic [7:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Clock pins watched for activity
    input wire logic rx_line_clock,
    input wire logic tx_reference_clock,
    input wire logic ext_trib_tx_clock,
    // Device control
    output logic device_reset,
    output logic counter_update,
    output logic [m13cfg_pkg::NUM_GROUPS-1:0] group_bypass,
    output logic trib_clock_source_sel,
    output logic rx_external_link_sel,
    output logic tx_external_link_sel,
    // Tributary pins and demux side
    input wire logic [m13cfg_pkg::NUM_LINES-1:0] trib_tx_clock,
    input wire logic [m13cfg_pkg::NUM_LINES-1:0] trib_tx_data,
    output logic [m13cfg_pkg::NUM_LINES-1:0] m12_tx_clock,
    output logic [m13cfg_pkg::NUM_LINES-1:0] m12_tx_data,
    output logic [m13cfg_pkg::NUM_GROUPS-1:0] ds2_tx_clock,
    output logic [m13cfg_pkg::NUM_GROUPS-1:0] ds2_tx_data,
    input wire logic [m13cfg_pkg::NUM_LINES-1:0] demux_rx_clock,
    input wire logic [m13cfg_pkg::NUM_LINES-1:0] demux_rx_data,
    input wire logic [m13cfg_pkg::NUM_GROUPS-1:0] ds2_rx_clock,
    input wire logic [m13cfg_pkg::NUM_GROUPS-1:0] ds2_rx_data,
    output logic [m13cfg_pkg::NUM_LINES-1:0] trib_rx_clock,
    output logic [m13cfg_pkg::NUM_LINES-1:0] trib_rx_data,
    // Data-link internal signals
    input wire logic rx_link_interrupt,
    input wire logic rx_link_end_of_message,
    input wire logic rx_link_serial_data,
    input wire logic rx_link_serial_clock,
    input wire logic tx_link_interrupt,
    input wire logic tx_link_underrun,
    input wire logic tx_link_serial_clock,
    output logic tx_link_serial_data,
    // Shared data-link pins
    input wire logic tx_sig_pin_in,
    output logic rx_clk_pin_out,
    output logic rx_clk_pin_oe,
    output logic rx_sig_pin_out,
    output logic rx_sig_pin_oe,
    output logic tx_clk_pin_out,
    output logic tx_clk_pin_oe,
    output logic tx_sig_pin_out,
    output logic tx_sig_pin_oe
);
    import m13cfg_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [NUM_ACT-1:0] clk_prev; // Synced clocks, one cycle old
        logic rd_prev; // Read strobe, one cycle old
        logic wr_prev; // Write strobe, one cycle old
        logic soft_reset; // Software reset bit
        logic [NUM_ACT-1:0] activity; // Clock activity flags
        logic [NUM_GROUPS-1:0] bypass; // Per-group bypass
        logic src_sel; // External tributary clock select
        logic rx_ext; // Receive external link select
        logic tx_ext; // Transmit external link select
        logic [3:0] pol; // Link pin polarities
        logic [7:0] rdata; // Read data
        logic rdata_oe; // Read data drive
        logic update; // Counter update pulse
        logic [NUM_LINES-1:0] rx_clk; // Receive tributary clocks
        logic [NUM_LINES-1:0] rx_dat; // Receive tributary data
        logic [NUM_LINES-1:0] m12_clk; // Clocks into the M12 stage
        logic [NUM_LINES-1:0] m12_dat; // Data into the M12 stage
        logic [NUM_GROUPS-1:0] ds2_clk; // Bypass DS2 clocks
        logic [NUM_GROUPS-1:0] ds2_dat; // Bypass DS2 data
    } m13cfg_state_s;

    m13cfg_state_s st;
    m13cfg_state_s next_st;

    // Synchronised bus, clock and tributary pins
    logic cs_n_s;
    logic a8_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] addr_s;
    logic [7:0] din_s;
    logic [NUM_ACT-1:0] clk_s;
    logic [2*NUM_LINES-1:0] trib_s;

    // Decoded strobes and clock edges
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic wr_end;
    logic [NUM_ACT-1:0] edges;

    // ==========================================================
    // Pin synchronisers
    m13cfg_sync #(.WIDTH(BUS_SYNC_W), .RESET_VALUE(RST_BUS_SYNC)) u_bus_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({chip_select_n, test_register_select, rd_n, wr_n, addr, data_in}),
        .sync_out({cs_n_s, a8_s, rd_n_s, wr_n_s, addr_s, din_s})
    );

    m13cfg_sync #(.WIDTH(NUM_ACT)) u_clk_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({rx_line_clock, tx_reference_clock, ext_trib_tx_clock}),
        .sync_out(clk_s)
    );

    m13cfg_sync #(.WIDTH(2*NUM_LINES)) u_trib_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({trib_tx_clock, trib_tx_data}),
        .sync_out(trib_s)
    );

    // True when the synced address selects the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // Bus strobes, gated by chip select and normal-mode space
    always_comb begin
        rd_act = !cs_n_s && !a8_s && !rd_n_s;
        wr_act = !cs_n_s && !a8_s && !wr_n_s;
        rd_start = rd_act && !st.rd_prev;
        wr_end = !wr_act && st.wr_prev;
        edges = clk_s & ~st.clk_prev;
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.clk_prev = clk_s;
        next_st.rd_prev = rd_act;
        next_st.wr_prev = wr_act;
        next_st.update = 1'b0;
        // Read capture; unused bits read as zero
        if (rd_start) begin
            next_st.rdata_oe = 1'b1;
            if (hit(addr_s, ADDR_MASTER)) begin
                next_st.rdata = 8'h00;
                next_st.rdata[BIT_RX_ACT] = st.activity[2];
                next_st.rdata[BIT_TX_ACT] = st.activity[1];
                next_st.rdata[BIT_EXT_ACT] = st.activity[0];
                next_st.rdata[BIT_SOFT_RESET] = st.soft_reset;
            end else if (hit(addr_s, ADDR_REVISION)) begin
                next_st.rdata = VERSION_CODE;
            end else if (hit(addr_s, ADDR_BYPASS)) begin
                next_st.rdata = {st.src_sel, st.bypass};
            end else if (hit(addr_s, ADDR_LINK_CFG)) begin
                next_st.rdata = {st.rx_ext, st.tx_ext, 2'h0, st.pol};
            end else begin
                next_st.rdata = 8'h00;
            end
        end else if (!rd_act) begin
            next_st.rdata_oe = 1'b0;
        end
        // Read clears flags; a fresh edge wins over the clear
        if (rd_start && hit(addr_s, ADDR_MASTER)) begin
            next_st.activity = edges;
        end else begin
            next_st.activity = st.activity | edges;
        end
        // Write commit at the end of the strobe
        if (wr_end) begin
            if (hit(addr_s, ADDR_MASTER)) begin
                next_st.soft_reset = din_s[BIT_SOFT_RESET];
            end else if (hit(addr_s, ADDR_REVISION)) begin
                next_st.update = 1'b1;
            end else if (hit(addr_s, ADDR_BYPASS)) begin
                next_st.src_sel = din_s[BIT_SRC_SEL];
                next_st.bypass = din_s[NUM_GROUPS-1:0];
            end else if (hit(addr_s, ADDR_LINK_CFG)) begin
                next_st.rx_ext = din_s[BIT_RX_EXT];
                next_st.tx_ext = din_s[BIT_TX_EXT];
                next_st.pol = din_s[3:0];
            end
        end
        // Tributary steering per group
        for (int g = 0; g < NUM_GROUPS; g++) begin
            for (int k = 0; k < LINES_PER_GROUP; k++) begin
                if (st.soft_reset) begin
                    // Hold every path quiet while in software reset
                    next_st.rx_clk[g*LINES_PER_GROUP+k] = 1'b0;
                    next_st.rx_dat[g*LINES_PER_GROUP+k] = 1'b0;
                    next_st.m12_clk[g*LINES_PER_GROUP+k] = 1'b0;
                    next_st.m12_dat[g*LINES_PER_GROUP+k] = 1'b0;
                end else if (st.bypass[g]) begin
                    // Only line 4n carries the DS2; the rest stay low
                    if (k == LINES_PER_GROUP-1) begin
                        next_st.rx_clk[g*LINES_PER_GROUP+k] = ds2_rx_clock[g];
                        next_st.rx_dat[g*LINES_PER_GROUP+k] = ds2_rx_data[g];
                    end else begin
                        next_st.rx_clk[g*LINES_PER_GROUP+k] = 1'b0;
                        next_st.rx_dat[g*LINES_PER_GROUP+k] = 1'b0;
                    end
                    next_st.m12_clk[g*LINES_PER_GROUP+k] = 1'b0;
                    next_st.m12_dat[g*LINES_PER_GROUP+k] = 1'b0;
                end else begin
                    // Normal M12 path
                    next_st.rx_clk[g*LINES_PER_GROUP+k] = demux_rx_clock[g*LINES_PER_GROUP+k];
                    next_st.rx_dat[g*LINES_PER_GROUP+k] = demux_rx_data[g*LINES_PER_GROUP+k];
                    next_st.m12_clk[g*LINES_PER_GROUP+k] =
                        trib_s[NUM_LINES+g*LINES_PER_GROUP+k];
                    next_st.m12_dat[g*LINES_PER_GROUP+k] = trib_s[g*LINES_PER_GROUP+k];
                end
            end
            // Bypass DS2 taken from line 4n only
            if (st.bypass[g] && !st.soft_reset) begin
                next_st.ds2_clk[g] = trib_s[NUM_LINES+g*LINES_PER_GROUP+3];
                next_st.ds2_dat[g] = trib_s[g*LINES_PER_GROUP+3];
            end else begin
                next_st.ds2_clk[g] = 1'b0;
                next_st.ds2_dat[g] = 1'b0;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
            st.soft_reset <= RST_SOFT_RESET;
            st.bypass <= RST_BYPASS;
            st.src_sel <= RST_SRC_SEL;
            st.rx_ext <= RST_RX_EXT;
            st.tx_ext <= RST_TX_EXT;
            st.pol <= RST_POL;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Data-link pins
    m13cfg_link_pins u_link (
        .clk(clk),
        .nrst(nrst),
        .rx_external_link_sel(st.rx_ext),
        .tx_external_link_sel(st.tx_ext),
        .polarity(st.pol),
        .rx_link_interrupt(rx_link_interrupt),
        .rx_link_end_of_message(rx_link_end_of_message),
        .rx_link_serial_data(rx_link_serial_data),
        .rx_link_serial_clock(rx_link_serial_clock),
        .tx_link_interrupt(tx_link_interrupt),
        .tx_link_underrun(tx_link_underrun),
        .tx_link_serial_clock(tx_link_serial_clock),
        .tx_sig_pin_in(tx_sig_pin_in),
        .rx_clk_pin_out(rx_clk_pin_out),
        .rx_clk_pin_oe(rx_clk_pin_oe),
        .rx_sig_pin_out(rx_sig_pin_out),
        .rx_sig_pin_oe(rx_sig_pin_oe),
        .tx_clk_pin_out(tx_clk_pin_out),
        .tx_clk_pin_oe(tx_clk_pin_oe),
        .tx_sig_pin_out(tx_sig_pin_out),
        .tx_sig_pin_oe(tx_sig_pin_oe),
        .tx_link_serial_data(tx_link_serial_data)
    );

    // ==========================================================
    // Outputs, all from flip-flops
    assign data_out = st.rdata;
    assign data_oe = st.rdata_oe;
    assign device_reset = st.soft_reset;
    assign counter_update = st.update;
    assign group_bypass = st.bypass;
    assign trib_clock_source_sel = st.src_sel;
    assign rx_external_link_sel = st.rx_ext;
    assign tx_external_link_sel = st.tx_ext;
    assign trib_rx_clock = st.rx_clk;
    assign trib_rx_data = st.rx_dat;
    assign m12_tx_clock = st.m12_clk;
    assign m12_tx_data = st.m12_dat;
    assign ds2_tx_clock = st.ds2_clk;
    assign ds2_tx_data = st.ds2_dat;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_SOFT_RESET_SET: assert property (
        wr_end && hit(addr_s, ADDR_MASTER) && din_s[0] |=> device_reset ##1 device_reset)
        else $error("software reset not taken");
    AST_SOFT_RESET_KEEP: assert property (
        device_reset && !(wr_end && hit(addr_s, ADDR_MASTER)) |=> device_reset)
        else $error("software reset cleared itself");
    AST_HW_RESET_DEFAULTS: assert property (
        $rose(nrst) |-> !device_reset && tx_external_link_sel && !rx_external_link_sel
            && group_bypass == 7'h00)
        else $error("wrong values after hardware reset");
    AST_FLAG_SET: assert property (
        edges[2] |=> st.activity[2])
        else $error("receive clock edge lost");
    AST_FLAG_CLEAR: assert property (
        rd_start && hit(addr_s, ADDR_MASTER) && !edges[1] |=> !st.activity[1])
        else $error("activity flag not cleared by read");
    AST_FLAG_PENDING: assert property (
        rd_start && hit(addr_s, ADDR_MASTER) && edges[0] |=> st.activity[0])
        else $error("edge during read lost");
    AST_UPDATE_PULSE: assert property (
        wr_end && hit(addr_s, ADDR_REVISION) |=> counter_update ##1 !counter_update)
        else $error("counter update pulse wrong");
    AST_VERSION_READ: assert property (
        rd_start && hit(addr_s, ADDR_REVISION) |=> data_oe && data_out == VERSION_CODE)
        else $error("version code misread");
    AST_RO_WRITE: assert property (
        wr_end && hit(addr_s, ADDR_REVISION) |=> $stable({group_bypass, trib_clock_source_sel,
            rx_external_link_sel, tx_external_link_sel, device_reset}))
        else $error("read-only write changed configuration");
    AST_BYPASS_LOW: assert property (
        (group_bypass[0] && !device_reset) [*2] |-> trib_rx_clock[2:0] == 3'h0
            && trib_rx_data[2:0] == 3'h0 && m12_tx_clock[3:0] == 4'h0)
        else $error("bypassed group lines not low");

endmodule // m13cfg_regs

`default_nettype wire

// [m13cfg_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Host processor model on the parallel register bus
module m13cfg_host (
    input wire logic clk,
    output logic cs_n,
    output logic a8,
    output logic [7:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] dout,
    input wire logic [7:0] din,
    input wire logic oe
);
    // Idle bus: no strobe, normal space
    initial begin
        {cs_n, rd_n, wr_n, a8, addr, dout} = {4'he, 16'h0000};
    end
    // Write: strobe low 4 cycles, qualifiers held 4 more, then scrambled
    task automatic wr(input logic t, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {cs_n, wr_n, a8, addr, dout} <= {2'b00, t, a, d};
        repeat (4) @(posedge clk);
        {cs_n, wr_n} <= 2'b11;
        repeat (4) @(posedge clk);
        {a8, addr, dout} <= {1'b0, ~a, ~d};
    endtask
    // Read: data taken at the edge where the enable is seen
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int i;
        @(posedge clk);
        {cs_n, rd_n, addr} <= {2'b00, a};
        for (i = 0; i < 12 && oe !== 1'b1; i++) @(posedge clk);
        d = (oe === 1'b1) ? din : 8'hxx;
        repeat (3) @(posedge clk);
        {cs_n, rd_n} <= 2'b11;
        repeat (4) @(posedge clk);
        addr <= ~a;
    endtask
endmodule // m13cfg_host
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ====
// Register bank bench against a behavioural model
module tb_top;
    import m13cfg_pkg::*;
    localparam logic [7:0] VER = 8'ha7; // Arbitrary value
    localparam logic [7:0] MSK [4] = '{8'he1, 8'hff, 8'hff, 8'hcf};
    logic clk = 1'b0, nrst = 1'b0, cs_n, a8, rd_n, wr_n, oe, dev_rst, cupd, src, rxe, txe;
    logic [7:0] addr, wdat, rdat, v, lk = '0, m [4];
    logic [2:0] act = '0;
    logic [6:0] byp, d2c = '0, d2d = '0, d2tc, d2td;
    logic [27:0] ttc = '0, ttd = '0, dmc = '0, dmd = '0, trc, trd, m12c, m12d;
    logic [8:0] w; // Expected link pin pairs and transmit data
    wire [8:0] lp; // Link pin pairs and transmit data from the design
    int seed = 47345, n_checks = 0, err_total = 0, n_upd = 0, u, k;
    always #50 clk = ~clk;
    // Counts update pulses
    always @(posedge clk) if (cupd === 1'b1) n_upd++;
    m13cfg_host m13cfg_host_inst (.clk(clk), .cs_n(cs_n), .a8(a8), .addr(addr), .rd_n(rd_n),
        .wr_n(wr_n), .dout(wdat), .din(rdat), .oe(oe));
    m13cfg_regs #(.VERSION_CODE(VER)) m13cfg_regs_inst (.clk(clk), .nrst(nrst),
        .chip_select_n(cs_n), .test_register_select(a8), .addr(addr), .rd_n(rd_n),
        .wr_n(wr_n), .data_in(wdat), .data_out(rdat), .data_oe(oe), .rx_line_clock(act[2]),
        .tx_reference_clock(act[1]), .ext_trib_tx_clock(act[0]), .device_reset(dev_rst),
        .counter_update(cupd), .group_bypass(byp), .trib_clock_source_sel(src),
        .rx_external_link_sel(rxe), .tx_external_link_sel(txe), .trib_tx_clock(ttc),
        .trib_tx_data(ttd), .m12_tx_clock(m12c), .m12_tx_data(m12d), .ds2_tx_clock(d2tc),
        .ds2_tx_data(d2td), .demux_rx_clock(dmc), .demux_rx_data(dmd), .ds2_rx_clock(d2c),
        .ds2_rx_data(d2d), .trib_rx_clock(trc), .trib_rx_data(trd),
        .rx_link_interrupt(lk[0]), .rx_link_end_of_message(lk[1]),
        .rx_link_serial_data(lk[2]), .rx_link_serial_clock(lk[3]), .tx_link_interrupt(lk[4]),
        .tx_link_underrun(lk[5]), .tx_link_serial_clock(lk[6]), .tx_link_serial_data(lp[0]),
        .tx_sig_pin_in(lk[7]), .rx_clk_pin_out(lp[8]), .rx_clk_pin_oe(lp[7]),
        .rx_sig_pin_out(lp[6]), .rx_sig_pin_oe(lp[5]), .tx_clk_pin_out(lp[4]),
        .tx_clk_pin_oe(lp[3]), .tx_sig_pin_out(lp[2]), .tx_sig_pin_oe(lp[1]));
    // Ends the run with the counts and the verdict
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Expected pin pair: pass-through when external, else open drain or strong high
    function automatic logic [1:0] pd(input logic x, input logic s, input logic a,
        input logic p);
        return x ? {s, 1'b1} : (p ? {a, 1'b1} : {1'b0, a});
    endfunction
    // Hardware reset and the model's reset image
    task automatic hw_reset();
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        m = '{8'h00, VER, 8'h00, 8'h40};
        repeat (3) @(posedge clk);
    endtask
    // Reads one register and compares its used bits
    task automatic chk(input int a);
        m13cfg_host_inst.rd(8'(a), v);
        `CHK(v & MSK[a], m[a])
    endtask
    // Hang guard
    initial begin
        #(100 * 30000);
        err_total++;
        give_verdict();
    end
    // ====
    // Main sequence
    initial begin
        hw_reset();
        `CHK(txe, 1'b1)
        for (k = 0; k < 4; k++) chk(k);
        for (k = 0; k < 6; k++) begin
            v = 8'($random(seed));
            m13cfg_host_inst.wr(1'b0, 8'h02, v);
            m[2] = v;
            v = 8'($random(seed)) & 8'hcf;
            m13cfg_host_inst.wr(1'b0, 8'h03, v);
            m[3] = v;
            chk(2);
            chk(3);
            `CHK({src, byp}, m[2])
            `CHK({rxe, txe}, m[3][7:6])
            {ttc, ttd, dmc, dmd} <= {4{28'($random(seed))}} ^ 112'($random(seed));
            {d2c, d2d, lk} <= 22'($random(seed));
            repeat (6) @(posedge clk);
            // Shared link pins follow the selects and polarities
            w = {pd(m[3][7], lk[3], lk[0], m[3][1]), pd(m[3][7], lk[2], lk[1], m[3][3]),
                pd(m[3][6], lk[6], lk[4], m[3][0]),
                (m[3][6] ? {2'b00, lk[7]} : {pd(1'b0, 1'b0, lk[5], m[3][2]), 1'b0})};
            `CHK(lp, w)
            // Bypassed groups use line 4n only
            for (u = 0; u < NUM_LINES; u++) begin
                `CHK(trd[u], m[2][u/4] ? (u % 4 == 3 && d2d[u/4]) : dmd[u])
                `CHK(trc[u], m[2][u/4] ? (u % 4 == 3 && d2c[u/4]) : dmc[u])
                `CHK({m12c[u], m12d[u]}, {2{!m[2][u/4]}} & {ttc[u], ttd[u]})
                if (u % 4 == 3)
                    `CHK({d2tc[u/4], d2td[u/4]}, {2{m[2][u/4]}} & {ttc[u], ttd[u]})
            end
        end
        u = n_upd;
        m13cfg_host_inst.wr(1'b0, 8'h01, 8'hff);
        @(posedge clk);
        `CHK(n_upd - u, 1)
        chk(1);
        m13cfg_host_inst.wr(1'b1, 8'h02, ~m[2]);
        chk(2);
        m13cfg_host_inst.rd(8'h07, v);
        `CHK(v, 8'h00)
        // Clock activity flags, then cleared by the read
        for (k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            act <= v[2:0];
            repeat (2) @(posedge clk);
            act <= 3'h0;
            repeat (5) @(posedge clk);
            m[0][7:5] = v[2:0];
            chk(0);
            m[0][7:5] = 3'h0;
            // External clock edge lands in the clearing cycle of this read
            fork
                chk(0);
                begin
                    @(posedge clk);
                    act <= 3'h1;
                    repeat (2) @(posedge clk);
                    act <= 3'h0;
                end
            join
            m[0][7:5] = 3'h1;
            chk(0);
        end
        m13cfg_host_inst.wr(1'b0, 8'h00, 8'h01);
        `CHK(dev_rst, 1'b1)
        @(posedge clk);
        `CHK({trc, trd, m12c, m12d}, 112'h0)
        m13cfg_host_inst.wr(1'b0, 8'h00, 8'h00);
        `CHK(dev_rst, 1'b0)
        m13cfg_host_inst.wr(1'b0, 8'h00, 8'h01);
        hw_reset();
        `CHK(dev_rst, 1'b0)
        for (k = 0; k < 4; k++) chk(k);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
